// ==== rtl/usart_control_and_baud_generator.sv ====
// Serial port control, status and baud generation with async and sync engines.
// Assumes an AXI4-Lite master on clk and pins that are outside the clock domain.
module usart_control_and_baud_generator (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       ce,
  input  wire logic [usart_pkg::AXI_AW-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [usart_pkg::AXI_AW-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  input  wire logic                       txPinI,
  output logic                            txPinO,
  output logic                            txPinOe,
  input  wire logic                       rxPinI,
  output logic                            rxPinO,
  output logic                            rxPinOe
);
  logic        clock_source_select_r, tx9_r, transmitter_enable_r, sync_r, high_speed_divisor_select_r, ninth_transmit_bit_r;
  logic        serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, address_detect_enable_r, framing_error_flag_r, overrun_error_flag_r, ninth_receive_bit_r;
  logic [7:0]  divisor_r, txHold_r, rxBuf_r;
  logic        txHoldFull_r, rxFull_r;
  logic        awHeld_r, wHeld_r, bvalid_r, rvalid_r;
  logic [31:0] awAddr_r, wData_r, rdata_r;
  logic [3:0]  wStrb_r;
  logic [1:0]  bresp_r, rresp_r, preCnt_r;
  logic        txS1_r, txS2_r, txPrev_r, rxS1_r, rxS2_r;
  logic        tick, sampleTick, wrEn, wrByte, divWrite, rdFire, rdPop;
  usart_pkg::line_e txState_r, rxState_r;
  logic [3:0]  txSub_r, txBit_r, rxSub_r, rxBit_r, syncBit_r;
  logic [8:0]  txShift_r, rxShift_r, syncShift_r;
  logic        txLine_r, sclk_r, syncBusy_r, syncIsRx_r, syncData_r;
  logic [2:0]  vote_r;
  logic        voted, asyncDone, syncDone, accept, rxLoad, srenSwSet, crenSwClr;
  logic        asyncTxEn, asyncRxEn, syncRxEn, syncTxEn, sRise, sFall, txLoad;
  logic [3:0]  txLast, rxLast;

  // AXI4-Lite write side: address and data taken in either order
  assign awready  = ce && !awHeld_r && !bvalid_r;
  assign wready   = ce && !wHeld_r && !bvalid_r;
  assign wrEn     = ce && awHeld_r && wHeld_r && !bvalid_r;
  assign wrByte   = wrEn && wStrb_r[0];
  assign divWrite = wrByte && awAddr_r == usart_pkg::DIVISOR_OFS;
  assign bvalid   = bvalid_r;
  assign bresp    = bresp_r;
  assign arready  = ce && !rvalid_r;
  assign rdFire   = arvalid && arready;
  assign rdPop    = rdFire && araddr == usart_pkg::RX_DATA_OFS;
  assign rvalid   = rvalid_r;
  assign rdata    = rdata_r;
  assign rresp    = rresp_r;

  function automatic logic mapped(input logic [31:0] a);
    mapped = a == usart_pkg::TX_CTL_OFS || a == usart_pkg::RX_CTL_OFS || a == usart_pkg::DIVISOR_OFS ||
             a == usart_pkg::TX_DATA_OFS || a == usart_pkg::RX_DATA_OFS || a == usart_pkg::STATUS_OFS;
  endfunction : mapped

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      bvalid_r <= 1'b0;
      awAddr_r <= 32'h0000_0000;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
      bresp_r  <= usart_pkg::RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
      if (wrEn) begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= mapped(awAddr_r) ? usart_pkg::RESP_OKAY : usart_pkg::RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read side; a read of receive data frees the buffer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= usart_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rdFire) begin
        rvalid_r <= 1'b1;
        rresp_r  <= mapped(araddr) ? usart_pkg::RESP_OKAY : usart_pkg::RESP_SLVERR;
        case (araddr)
          usart_pkg::TX_CTL_OFS:  rdata_r <= {24'h000000, clock_source_select_r, tx9_r, transmitter_enable_r, sync_r, 1'b0, high_speed_divisor_select_r,
                                              !txLoad && txState_r == usart_pkg::LINE_IDLE &&
                                              !(syncBusy_r && !syncIsRx_r), ninth_transmit_bit_r};
          usart_pkg::RX_CTL_OFS:  rdata_r <= {24'h000000, serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, address_detect_enable_r, framing_error_flag_r,
                                              overrun_error_flag_r, ninth_receive_bit_r};
          usart_pkg::DIVISOR_OFS: rdata_r <= {24'h000000, divisor_r};
          usart_pkg::RX_DATA_OFS: rdata_r <= {24'h000000, rxBuf_r};
          usart_pkg::STATUS_OFS:  rdata_r <= {30'h00000000, !txHoldFull_r, rxFull_r};
          default:                rdata_r <= 32'h0000_0000;
        endcase
      end else if (rvalid_r && rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Control registers; hardware clear of single receive loses to a software set
  assign srenSwSet = wrByte && awAddr_r == usart_pkg::RX_CTL_OFS && wData_r[usart_pkg::RX_SINGLE_RECEIVE_ENABLE_BIT];
  assign crenSwClr = wrByte && awAddr_r == usart_pkg::RX_CTL_OFS && !wData_r[usart_pkg::RX_CONTINUOUS_RECEIVE_ENABLE_BIT];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {clock_source_select_r, tx9_r, transmitter_enable_r, sync_r} <= usart_pkg::TX_CTL_RST[7:4];
      {high_speed_divisor_select_r, ninth_transmit_bit_r}                <= {usart_pkg::TX_CTL_RST[2], usart_pkg::TX_CTL_RST[0]};
      {serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, address_detect_enable_r} <= usart_pkg::RX_CTL_RST[7:3];
      divisor_r <= usart_pkg::DIVISOR_RST;
    end else if (ce) begin
      if (wrByte && awAddr_r == usart_pkg::TX_CTL_OFS) begin
        clock_source_select_r <= wData_r[usart_pkg::TX_CLOCK_SOURCE_SELECT_BIT];
        tx9_r  <= wData_r[usart_pkg::TX_NINE_BIT];
        transmitter_enable_r <= wData_r[usart_pkg::TX_EN_BIT];
        sync_r <= wData_r[usart_pkg::TX_SYNC_BIT];
        high_speed_divisor_select_r <= wData_r[usart_pkg::TX_HIGH_SPEED_DIVISOR_SELECT_BIT];
        ninth_transmit_bit_r <= wData_r[usart_pkg::TX_D9_BIT];
      end
      if (wrByte && awAddr_r == usart_pkg::RX_CTL_OFS) begin
        serial_port_enable_r  <= wData_r[usart_pkg::RX_SERIAL_PORT_ENABLE_BIT];
        rx9_r   <= wData_r[usart_pkg::RX_NINE_BIT];
        single_receive_enable_r  <= wData_r[usart_pkg::RX_SINGLE_RECEIVE_ENABLE_BIT];
        continuous_receive_enable_r  <= wData_r[usart_pkg::RX_CONTINUOUS_RECEIVE_ENABLE_BIT];
        address_detect_enable_r <= wData_r[usart_pkg::RX_ADDRESS_DETECT_ENABLE_BIT];
      end else if (syncDone && syncIsRx_r && clock_source_select_r) begin
        single_receive_enable_r <= 1'b0;
      end
      if (divWrite) begin
        divisor_r <= wData_r[7:0];
      end
    end
  end

  // Baud timer and prescaler
  baud_divider_timer #(.W(8)) baudTimer (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .divisor (divisor_r),
    .restart (divWrite),
    .tick    (tick)
  );
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      preCnt_r <= 2'b00;
    end else if (ce) begin
      if (divWrite) begin
        preCnt_r <= 2'b00;
      end else if (tick) begin
        preCnt_r <= preCnt_r + 2'b01;
      end
    end
  end
  // Async sample tick is 1/16 bit; sync tick is a half clock period
  assign sampleTick = tick && (sync_r ? preCnt_r[0] : (high_speed_divisor_select_r || preCnt_r == usart_pkg::LOW_PRESCALE_LAST));

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {txS1_r, txS2_r, txPrev_r, rxS1_r, rxS2_r} <= 5'b11111;
    end else if (ce) begin
      txS1_r   <= txPinI;
      txS2_r   <= txS1_r;
      txPrev_r <= txS2_r;
      rxS1_r   <= rxPinI;
      rxS2_r   <= rxS1_r;
    end
  end

  // Mode decode
  assign asyncTxEn = serial_port_enable_r && !sync_r && transmitter_enable_r;
  assign asyncRxEn = serial_port_enable_r && !sync_r && continuous_receive_enable_r;
  assign syncRxEn  = serial_port_enable_r && sync_r && (continuous_receive_enable_r || (single_receive_enable_r && clock_source_select_r));
  assign syncTxEn  = serial_port_enable_r && sync_r && transmitter_enable_r && !syncRxEn;
  assign txLast    = tx9_r ? 4'h8 : 4'h7;
  assign rxLast    = rx9_r ? 4'h8 : 4'h7;
  assign txLoad    = asyncTxEn && txHoldFull_r && txState_r == usart_pkg::LINE_IDLE;

  // Hold register: a software write wins over the load that empties it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txHold_r     <= 8'h00;
      txHoldFull_r <= 1'b0;
    end else if (ce) begin
      if (wrByte && awAddr_r == usart_pkg::TX_DATA_OFS) begin
        txHold_r     <= wData_r[7:0];
        txHoldFull_r <= 1'b1;
      end else if (txLoad || (syncTxEn && !syncBusy_r && txHoldFull_r)) begin
        txHoldFull_r <= 1'b0;
      end
    end
  end

  // Asynchronous transmitter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txState_r <= usart_pkg::LINE_IDLE;
      txSub_r   <= 4'h0;
      txBit_r   <= 4'h0;
      txShift_r <= 9'h000;
      txLine_r  <= 1'b1;
    end else if (ce) begin
      if (!asyncTxEn && txState_r != usart_pkg::LINE_IDLE) begin
        txState_r <= usart_pkg::LINE_IDLE;
        txLine_r  <= 1'b1;
      end else if (txLoad) begin
        txState_r <= usart_pkg::LINE_START;
        txShift_r <= {ninth_transmit_bit_r, txHold_r};
        txSub_r   <= 4'h0;
        txLine_r  <= 1'b0;
      end else if (sampleTick && txState_r != usart_pkg::LINE_IDLE) begin
        txSub_r <= txSub_r + 4'h1;
        if (txSub_r == usart_pkg::OVERSAMPLE_LAST) begin
          case (txState_r)
            usart_pkg::LINE_START: begin
              txState_r <= usart_pkg::LINE_DATA;
              txBit_r   <= 4'h0;
              txLine_r  <= txShift_r[0];
            end
            usart_pkg::LINE_DATA: begin
              txBit_r  <= txBit_r + 4'h1;
              txLine_r <= (txBit_r == txLast) ? 1'b1 : txShift_r[txBit_r + 4'h1];
              if (txBit_r == txLast) begin
                txState_r <= usart_pkg::LINE_STOP;
              end
            end
            default: begin
              txState_r <= usart_pkg::LINE_IDLE;
            end
          endcase
        end
      end
    end
  end

  // Asynchronous receiver with majority vote on samples 7, 8 and 9
  assign voted     = (vote_r[0] & vote_r[1]) | (vote_r[1] & vote_r[2]) | (vote_r[0] & vote_r[2]);
  assign asyncDone = sampleTick && rxState_r == usart_pkg::LINE_STOP && rxSub_r == usart_pkg::OVERSAMPLE_LAST;
  assign accept    = !(rx9_r && address_detect_enable_r) || rxShift_r[8];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxState_r <= usart_pkg::LINE_IDLE;
      rxSub_r   <= 4'h0;
      rxBit_r   <= 4'h0;
      rxShift_r <= 9'h000;
      vote_r    <= 3'b111;
    end else if (ce) begin
      if (!asyncRxEn) begin
        rxState_r <= usart_pkg::LINE_IDLE;
      end else if (rxState_r == usart_pkg::LINE_IDLE) begin
        if (!rxS2_r) begin
          rxState_r <= usart_pkg::LINE_START;
          rxSub_r   <= 4'h0;
          rxShift_r <= 9'h000;
        end
      end else if (sampleTick) begin
        rxSub_r <= rxSub_r + 4'h1;
        if (rxSub_r >= usart_pkg::VOTE_FIRST && rxSub_r <= usart_pkg::VOTE_LAST) begin
          vote_r <= {vote_r[1:0], rxS2_r};
        end
        if (rxSub_r == usart_pkg::OVERSAMPLE_LAST) begin
          case (rxState_r)
            usart_pkg::LINE_START: begin
              rxState_r <= voted ? usart_pkg::LINE_IDLE : usart_pkg::LINE_DATA; // False start is dropped
              rxBit_r   <= 4'h0;
            end
            usart_pkg::LINE_DATA: begin
              rxShift_r[rxBit_r] <= voted;
              rxBit_r            <= rxBit_r + 4'h1;
              if (rxBit_r == rxLast) begin
                rxState_r <= usart_pkg::LINE_STOP;
              end
            end
            default: begin
              rxState_r <= usart_pkg::LINE_IDLE;
            end
          endcase
        end
      end
    end
  end

  // Synchronous engine: data set on falling clock edge, sampled on rising edge
  assign sRise    = clock_source_select_r ? (sampleTick && syncBusy_r && !sclk_r) : (txS2_r && !txPrev_r);
  assign sFall    = clock_source_select_r ? (sampleTick && syncBusy_r && sclk_r) : (!txS2_r && txPrev_r);
  assign syncDone = syncBusy_r && sFall && syncBit_r == (syncIsRx_r ? rxLast : txLast);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncBusy_r  <= 1'b0;
      syncIsRx_r  <= 1'b0;
      syncBit_r   <= 4'h0;
      syncShift_r <= 9'h000;
      syncData_r  <= 1'b1;
      sclk_r      <= 1'b0;
    end else if (ce) begin
      if (!syncBusy_r) begin
        sclk_r <= 1'b0;
        if (syncRxEn || (syncTxEn && txHoldFull_r)) begin
          syncBusy_r  <= 1'b1;
          syncIsRx_r  <= syncRxEn;
          syncBit_r   <= 4'h0;
          syncShift_r <= {ninth_transmit_bit_r, txHold_r};
          syncData_r  <= txHold_r[0];
        end
      end else if (!(syncIsRx_r ? syncRxEn : syncTxEn)) begin
        syncBusy_r <= 1'b0;
      end else begin
        if (clock_source_select_r && sampleTick) begin
          sclk_r <= !sclk_r;
        end
        if (sRise && syncIsRx_r) begin
          syncShift_r[syncBit_r] <= rxS2_r;
        end
        if (sFall) begin
          syncBit_r  <= syncBit_r + 4'h1;
          syncData_r <= syncShift_r[syncBit_r + 4'h1];
          if (syncDone) begin
            syncBusy_r <= syncIsRx_r && continuous_receive_enable_r;
            syncBit_r  <= 4'h0;
            // Past the last bit the shift index reaches bit 8, or runs off the end in 9-bit mode; rest the line high
            syncData_r <= 1'b1;
          end
        end
      end
    end
  end

  // Receive buffer and error flags; overrun set wins over the clear
  assign rxLoad = (asyncDone && accept) || (syncDone && syncIsRx_r);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxBuf_r  <= 8'h00;
      rxFull_r <= 1'b0;
      framing_error_flag_r   <= usart_pkg::RX_CTL_RST[usart_pkg::RX_FRAMING_ERROR_FLAG_BIT];
      overrun_error_flag_r   <= usart_pkg::RX_CTL_RST[usart_pkg::RX_OVERRUN_ERROR_FLAG_BIT];
      ninth_receive_bit_r   <= usart_pkg::RX_CTL_RST[usart_pkg::RX_D9_BIT];
    end else if (ce) begin
      if (rxLoad && rxFull_r) begin
        overrun_error_flag_r <= 1'b1;
      end else if (crenSwClr) begin
        overrun_error_flag_r <= 1'b0;
      end
      if (rxLoad && !rxFull_r) begin
        rxBuf_r  <= asyncDone ? rxShift_r[7:0] : syncShift_r[7:0];
        ninth_receive_bit_r   <= asyncDone ? rxShift_r[8] : syncShift_r[8];
        framing_error_flag_r   <= asyncDone && !voted;
        rxFull_r <= 1'b1;
      end else if (rdPop) begin
        rxFull_r <= 1'b0;
      end
    end
  end

  // Pins stay released until the port is enabled
  assign txPinO  = sync_r ? sclk_r : txLine_r;
  assign txPinOe = serial_port_enable_r && (!sync_r || clock_source_select_r);
  assign rxPinO  = syncData_r;
  assign rxPinOe = serial_port_enable_r && sync_r && syncBusy_r && !syncIsRx_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  div_restart_a: assert property (ce && divWrite |=> preCnt_r == 2'b00 &&
                                  tick == (ce && divisor_r == 8'h00))
    else $error("divisor write did not restart timer");
  bit3_zero_a: assert property (rdFire && araddr == usart_pkg::TX_CTL_OFS && txState_r == usart_pkg::LINE_IDLE &&
                                !txLoad && !syncBusy_r |=> !rdata_r[3] && rdata_r[1])
    else $error("transmit control read wrong");
  overrun_hold_a: assert property (ce && overrun_error_flag_r && !crenSwClr |=> overrun_error_flag_r)
    else $error("overrun flag lost");
  single_clear_a: assert property (ce && syncDone && syncIsRx_r && clock_source_select_r && !srenSwSet
                                   && !(wrByte && awAddr_r == usart_pkg::RX_CTL_OFS) |=> !single_receive_enable_r)
    else $error("single receive not cleared");
  addr_filter_a: assert property (ce && asyncDone && rx9_r && address_detect_enable_r && !rxShift_r[8] && !rdPop
                                  |=> $stable(rxFull_r) && $stable(rxBuf_r))
    else $error("address filter let a character through");
  frame_err_a: assert property (ce && asyncDone && accept && !rxFull_r && !voted |=> framing_error_flag_r && rxFull_r)
    else $error("framing error not flagged");
  rx_priority_a: assert property (ce && syncRxEn && !syncBusy_r |=> syncBusy_r && syncIsRx_r)
    else $error("transmit won over receive");
  slave_clock_a: assert property (sync_r && !clock_source_select_r |-> !txPinOe)
    else $error("slave drives clock pin");
  async_pins_a: assert property (serial_port_enable_r && !sync_r |-> txPinOe && !rxPinOe)
    else $error("async pin directions wrong");

  async_rx_c: cover property (asyncDone && accept);
  sync_tx_c: cover property (syncDone && !syncIsRx_r);
  overrun_c: cover property ($rose(overrun_error_flag_r));
endmodule : usart_control_and_baud_generator

// ==== rtl/usart_pkg.sv ====
// Shared constants for the serial port control and baud generator.
// Assumes a single system clock; register offsets are byte addresses on AXI4-Lite.
package usart_pkg;
  localparam int          AXI_AW        = 32;
  localparam logic [31:0] TX_CTL_OFS    = 32'h0000_0000;
  localparam logic [31:0] RX_CTL_OFS    = 32'h0000_0004;
  localparam logic [31:0] DIVISOR_OFS   = 32'h0000_0008;
  localparam logic [31:0] TX_DATA_OFS   = 32'h0000_000C;
  localparam logic [31:0] RX_DATA_OFS   = 32'h0000_0010;
  localparam logic [31:0] STATUS_OFS    = 32'h0000_0014;
  // Transmit control/status fields
  localparam int TX_CLOCK_SOURCE_SELECT_BIT  = 7;
  localparam int TX_NINE_BIT  = 6;
  localparam int TX_EN_BIT    = 5;
  localparam int TX_SYNC_BIT  = 4;
  localparam int TX_HIGH_SPEED_DIVISOR_SELECT_BIT  = 2;
  localparam int TX_SHIFT_REGISTER_EMPTY_BIT  = 1;
  localparam int TX_D9_BIT    = 0;
  // Receive control/status fields
  localparam int RX_SERIAL_PORT_ENABLE_BIT  = 7;
  localparam int RX_NINE_BIT  = 6;
  localparam int RX_SINGLE_RECEIVE_ENABLE_BIT  = 5;
  localparam int RX_CONTINUOUS_RECEIVE_ENABLE_BIT  = 4;
  localparam int RX_ADDRESS_DETECT_ENABLE_BIT = 3;
  localparam int RX_FRAMING_ERROR_FLAG_BIT  = 2;
  localparam int RX_OVERRUN_ERROR_FLAG_BIT  = 1;
  localparam int RX_D9_BIT    = 0;
  // Status register fields
  localparam int ST_RXFULL_BIT = 0;
  localparam int ST_TXHOLD_BIT = 1;
  // Reset values
  localparam logic [7:0] TX_CTL_RST  = 8'h02;
  localparam logic [7:0] RX_CTL_RST  = 8'h00;
  localparam logic [7:0] DIVISOR_RST = 8'h00;
  // Timing: 16 samples per asynchronous bit, divisor 64 = 16 * 4, 16 = 16 * 1, 4 = 2 half periods * 2
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [1:0] LOW_PRESCALE_LAST = 2'h3;
  localparam logic [3:0] VOTE_FIRST = 4'h7;
  localparam logic [3:0] VOTE_LAST  = 4'h9;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {LINE_IDLE, LINE_START, LINE_DATA, LINE_STOP} line_e;
endpackage : usart_pkg

// ==== rtl/baud_divider_timer.sv ====
// Free-running divisor timer producing one tick every (divisor + 1) clocks.
// Assumes restart comes from a register write on the same clock.
module baud_divider_timer #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] divisor,
  input  wire logic         restart,
  output logic              tick
);
  logic [W-1:0] count_r;

  assign tick = ce && !restart && (count_r == divisor);

  // Restart drops the old period at once
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_r <= '0;
    end else if (ce) begin
      if (restart || count_r == divisor) begin
        count_r <= '0;
      end else begin
        count_r <= count_r + 1'b1;
      end
    end
  end
endmodule : baud_divider_timer

// ==== verification/serial_peer.sv ====
// Far-side serial peer: drives the receive/data line and, as clock master, the clock line.
// Assumes the bench calls its tasks; both lines rest at their pulled idle levels between frames.
module serial_peer;
  timeunit 1ns;
  timeprecision 1ns;
  logic dataLine = 1'b1;
  logic clkLine  = 1'b0;
  // A low stop bit is sent only when a scenario asks for a framing fault
  task automatic send_async(input logic [8:0] d, input int nb, input int bitNs, input logic stp);
    dataLine <= 1'b0;
    #(bitNs);
    for (int i = 0; i < nb; i++) begin
      dataLine <= d[i];
      #(bitNs);
    end
    dataLine <= stp;
    #(bitNs);
    dataLine <= 1'b1;
  endtask : send_async
  // Clock stands still outside the frame; data changes while the clock is low
  task automatic send_sync(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      dataLine <= d[i];
      #400 clkLine <= 1'b1;
      #400 clkLine <= 1'b0;
    end
    dataLine <= 1'b1;
  endtask : send_sync
endmodule : serial_peer

// ==== verification/tb_top.sv ====
// Self-checking bench: AXI4-Lite master, byte queue model, transmit line decoder.
// Assumes the peer model drives each pin whenever the block does not.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] TXC = usart_pkg::TX_CTL_OFS;
  localparam logic [31:0] RXC = usart_pkg::RX_CTL_OFS;
  localparam logic [31:0] RXD = usart_pkg::RX_DATA_OFS;
  logic        clk = 0, rstn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, txPinO, txPinOe, rxPinO, rxPinOe;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, q;
  logic [1:0]  bresp, rresp, rs;
  logic [3:0]  wstrb = 4'hF;
  logic [8:0]  v;
  int          error_cnt = 0, tests_run = 0, seed = 37960, dv, n, bitNs;
  int          model[$];
  serial_peer serial_peer_i ();
  wire txLine = txPinOe ? txPinO : serial_peer_i.clkLine;
  wire rxLine = rxPinOe ? rxPinO : serial_peer_i.dataLine;
  usart_control_and_baud_generator usart_control_and_baud_generator_i (.clk, .rstn, .ce, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .txPinI(txLine), .txPinO, .txPinOe, .rxPinI(rxLine), .rxPinO, .rxPinOe);
  always #50 clk = ~clk;
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", w, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // Ready is looked at mid-cycle, where it is settled, and acted on at the next edge
  task automatic axi(input logic wr, input logic [31:0] a, input logic [7:0] d);
    logic ta, tw, tr, td;
    @(posedge clk);
    {awaddr, araddr, wdata} <= {a, a, 24'h0, d};
    {awvalid, wvalid, bready, arvalid, rready} <= {wr, wr, wr, !wr, !wr};
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      {ta, tw, tr} = {awready, wready, arready};
      td = wr ? bvalid : rvalid;
      rs = wr ? bresp : rresp;
      q = rdata;
      @(posedge clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tr) arvalid <= 0;
      if (td) break;
    end
    {bready, rready} <= 2'b00;
    if (n == 50) begin
      error_cnt++;
      finish_test();
    end
  endtask : axi
  task automatic rd_chk(input string w, input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    axi(0, a, 0);
    check(w, q & m, e);
  endtask : rd_chk
  task automatic rxf(input logic [8:0] x, input int nb, input logic stp, input logic keep);
    serial_peer_i.send_async(x, nb, bitNs, stp);
    // A low stop bit can look like a new start; let that false start die out
    repeat (bitNs / 100 + 8) @(posedge clk);
    if (keep) model.push_back(x[7:0]);
  endtask : rxf
  task automatic pop_chk;
    rd_chk("rx data", RXD, 32'hFF, model.pop_front());
  endtask : pop_chk
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1;
    rd_chk("tx ctl reset", TXC, 32'hFF, 32'h02);
    rd_chk("rx ctl reset", RXC, 32'hFE, 32'h00);
    rd_chk("divisor reset", usart_pkg::DIVISOR_OFS, 32'hFF, 32'h00);
    axi(1, TXC, 8'hFF);
    rd_chk("tx ctl bits", TXC, 32'hFF, 32'hF7);
    axi(1, 32'h40, 8'h55);
    check("unmapped resp", rs, usart_pkg::RESP_SLVERR);
    dv = $random(seed) & 3;
    bitNs = 6400 * (dv + 1);
    axi(1, usart_pkg::DIVISOR_OFS, dv[7:0]);
    axi(1, TXC, 8'h00);
    axi(1, RXC, 8'h90);
    repeat (3) begin
      rxf(9'($random(seed)) & 9'h0FF, 8, 1, 1);
      pop_chk();
    end
    rxf(9'h0A5, 8, 0, 1);
    rd_chk("framing set", RXC, 32'h04, 32'h04);
    pop_chk();
    rxf(9'h03C, 8, 1, 1);
    rd_chk("framing clear", RXC, 32'h04, 32'h00);
    pop_chk();
    rxf(9'h011, 8, 1, 1);
    rxf(9'h022, 8, 1, 0);
    rd_chk("overrun set", RXC, 32'h02, 32'h02);
    axi(1, RXC, 8'h80);
    rd_chk("overrun clear", RXC, 32'h02, 32'h00);
    pop_chk();
    axi(1, RXC, 8'hD8);
    rxf(9'h0C3, 9, 1, 0);
    rd_chk("address drop", usart_pkg::STATUS_OFS, 32'h01, 32'h00);
    rxf(9'h1C4, 9, 1, 1);
    rd_chk("ninth rx bit", RXC, 32'h01, 32'h01);
    pop_chk();
    axi(1, TXC, 8'h24);
    v = 9'($random(seed)) & 9'h0FF;
    axi(1, usart_pkg::TX_DATA_OFS, v[7:0]);
    for (n = 0; n < 9999 && txLine; n++) @(posedge clk);
    check("tx start seen", n < 9999, 1);
    if (n >= 9999) finish_test();
    #(bitNs / 8 + 50);
    for (int i = 0; i < 10; i++) begin
      check("tx line", txLine, i == 0 ? 1'b0 : i == 9 ? 1'b1 : v[i-1]);
      #(bitNs / 4);
    end
    rd_chk("shift empty", TXC, 32'h0A, 32'h02);
    // Port off while the mode changes, so the pin handover makes no false clock edge
    axi(1, RXC, 8'h00);
    axi(1, TXC, 8'h10);
    axi(1, RXC, 8'h90);
    v = 9'h0B6;
    model.push_back(v);
    serial_peer_i.send_sync(v[7:0]);
    repeat (8) @(posedge clk);
    pop_chk();
    axi(1, RXC, 8'h00);
    axi(1, TXC, 8'h90);
    axi(1, RXC, 8'hA0);
    // Peer holds the data line high, so one master-clocked character reads all ones
    repeat (40 * (dv + 1) + 20) @(posedge clk);
    rd_chk("single clear", RXC, 32'h20, 32'h00);
    model.push_back(8'hFF);
    pop_chk();
    finish_test();
  end
endmodule : tb_top
